// file: hw/bmfs_defs.vh
// Constants for the bridge mode and fault supervisor
`ifndef BMFS_DEFS_VH
`define BMFS_DEFS_VH
// Timing figures in nanoseconds, clock period in nanoseconds
`define BMFS_CLK_NS 40
`define BMFS_WAKE_NS 1000000
`define BMFS_SLEEP_NS 1000000
`define BMFS_RETRY_NS 1600000
`define BMFS_PUP_FLAG_NS 10000
`define BMFS_OLD_TEST_NS 400000
// Derived cycle counts (least times round up)
`define BMFS_WAKE_CYC ((`BMFS_WAKE_NS + `BMFS_CLK_NS - 1) / `BMFS_CLK_NS)
`define BMFS_SLEEP_CYC ((`BMFS_SLEEP_NS + `BMFS_CLK_NS - 1) / `BMFS_CLK_NS)
`define BMFS_RETRY_CYC ((`BMFS_RETRY_NS + `BMFS_CLK_NS - 1) / `BMFS_CLK_NS)
`define BMFS_PUP_FLAG_CYC (`BMFS_PUP_FLAG_NS / `BMFS_CLK_NS)
`define BMFS_OLD_TEST_CYC (`BMFS_OLD_TEST_NS / `BMFS_CLK_NS)
// Interface mode encodings
`define BMFS_IF_4PIN 2'h0
`define BMFS_IF_2PIN 2'h1
`define BMFS_IF_PAR 2'h2
`define BMFS_IF_IND 2'h3
// Load type for the open-load test
`define BMFS_LOAD_BRIDGE 2'h0
`define BMFS_LOAD_TO_SUPPLY 2'h1
`define BMFS_LOAD_TO_GND 2'h2
`endif

// file: hw/bmfs_sync.v
// Two-stage synchroniser for a single level
`timescale 1ns/100ps
module bmfs_sync (
    input wire clk_i,
    input wire rstn_i,
    input wire d_i,
    output reg q_o
);
    reg meta_reg;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// file: hw/bmfs_top.v
// Sleep, wake and fault supervision for a dual H-bridge driver
`timescale 1ns/100ps
`include "bmfs_defs.vh"

// Notes on behaviour
// - Sleep pin low: pump, regulators off, outputs Hi-Z
// - Sleep pin high returns to operating automatically
// - Fault flag pulses briefly at power-up
// - Sleep completes only after sleep entry delay
// - Any of four faults enters fault mode
// - Bridge state per fault; all faults flag
// - Undervoltage: both bridges Hi-Z, circuits off, auto-recover
// - Overcurrent tri-states per interface, retries after delay
// - Open load two-pin/parallel: bridges keep running
// - Open load independent: half-bridge keeps running
// - Open load flag held until reset cycle
// - Over-temperature: both bridges Hi-Z until cooled
// - Supply load: sink current, low comparator proves load
// - Ground load: source current, high comparator decides
// - Open-load test at power-up and wake, in time
module bmfs_top #(
    parameter WAKE_CYC = `BMFS_WAKE_CYC,
    parameter SLEEP_CYC = `BMFS_SLEEP_CYC,
    parameter RETRY_CYC = `BMFS_RETRY_CYC,
    parameter PUP_CYC = `BMFS_PUP_FLAG_CYC,
    parameter OLD_CYC = `BMFS_OLD_TEST_CYC,
    parameter CW = 17
) (
    input wire clk_i,
    input wire rstn_i,
    input wire sleep_bar_i,
    input wire [1:0] if_mode_i,
    input wire [1:0] load_type_i,
    input wire supply_low_i,
    input wire [3:0] oc_half_i,
    input wire thermal_hot_i,
    input wire thermal_cool_i,
    input wire output_one_low_side_sense_i,
    input wire output_one_high_side_sense_i,
    input wire [3:0] old_bridge_open_i,
    output reg fault_flag_n_out_o,
    output reg [3:0] half_enable_o,
    output reg circuits_on_o,
    output reg ready_o,
    output reg output_one_sink_o,
    output reg output_one_source_o,
    output reg open_load_fault_o,
    output reg overcurrent_trip_o,
    output reg thermal_trip_o
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [4:0] ST_SLEEP = 5'h01;
    localparam [4:0] ST_WAKE = 5'h02;
    localparam [4:0] ST_RUN = 5'h04;
    localparam [4:0] ST_SLEEPING = 5'h08;
    localparam [4:0] ST_LOCKOUT = 5'h10;

    reg [4:0] state_reg, state_next;
    reg [CW-1:0] cnt_reg, cnt_next;
    reg [CW-1:0] retry_reg, retry_next;
    reg [CW-1:0] pup_reg, pup_next;
    reg [3:0] oc_reg, oc_next;
    reg old_reg, old_next;
    reg hot_reg, hot_next;
    reg testing_reg, testing_next;
    reg pwr_first_reg;
    wire sleep_bar_s;
    reg [3:0] oc_mask;
    reg old_hit;

    // Truncates an integer cycle count to the counter width
    function [CW-1:0] cyc;
        input integer n;
        begin
            cyc = n[CW-1:0];
        end
    endfunction

    // ****************************************************************
    // Sleep pin synchroniser
    // ****************************************************************
    bmfs_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(sleep_bar_i),
        .q_o(sleep_bar_s)
    );

    // Half-bridges to drop on overcurrent per interface mode
    always @* begin
        case (if_mode_i)
            `BMFS_IF_PAR: oc_mask = (|oc_reg) ? 4'hF : 4'h0;
            `BMFS_IF_IND: oc_mask = oc_reg;
            default: oc_mask = {{2{|oc_reg[3:2]}}, {2{|oc_reg[1:0]}}};
        endcase
    end

    // Open-load verdict per load type
    always @* begin
        case (load_type_i)
            `BMFS_LOAD_TO_SUPPLY:
                old_hit = ~output_one_low_side_sense_i;
            `BMFS_LOAD_TO_GND:
                old_hit = ~output_one_high_side_sense_i;
            default: old_hit = |old_bridge_open_i;
        endcase
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        retry_next = retry_reg;
        oc_next = oc_reg;
        old_next = old_reg;
        testing_next = testing_reg;
        pup_next = (pup_reg != {CW{1'b0}}) ? pup_reg - 1'b1 : pup_reg;
        // Over-temperature sets on hot, clears once cooled by hysteresis
        if (thermal_hot_i)
            hot_next = 1'b1;
        else if (thermal_cool_i)
            hot_next = 1'b0;
        else
            hot_next = hot_reg;
        // Overcurrent latches and retries after the delay
        if (oc_reg != 4'h0) begin
            // Resample at retry; a standing fault waits a full delay again
            if (retry_reg == {CW{1'b0}}) begin
                oc_next = oc_half_i;
                retry_next = cyc(RETRY_CYC) - 1'b1;
            end else
                retry_next = retry_reg - 1'b1;
        end else if (oc_half_i != 4'h0) begin
            oc_next = oc_half_i;
            retry_next = cyc(RETRY_CYC) - 1'b1;
        end
        case (state_reg)
            ST_SLEEP: begin
                if (sleep_bar_s) begin
                    state_next = ST_WAKE;
                    cnt_next = cyc(WAKE_CYC) - 1'b1;
                    testing_next = 1'b1;
                    old_next = 1'b0;
                end
            end
            ST_WAKE: begin
                if (testing_reg && cnt_reg == cyc(WAKE_CYC - OLD_CYC)) begin
                    testing_next = 1'b0;
                    old_next = old_hit;
                end
                if (!sleep_bar_s) begin
                    state_next = ST_SLEEPING;
                    cnt_next = cyc(SLEEP_CYC) - 1'b1;
                    testing_next = 1'b0;
                end else if (cnt_reg == {CW{1'b0}})
                    state_next = ST_RUN;
                else
                    cnt_next = cnt_reg - 1'b1;
            end
            ST_RUN: begin
                if (!sleep_bar_s) begin
                    state_next = ST_SLEEPING;
                    cnt_next = cyc(SLEEP_CYC) - 1'b1;
                end
            end
            ST_SLEEPING: begin
                if (sleep_bar_s)
                    state_next = ST_RUN;
                else if (cnt_reg == {CW{1'b0}})
                    state_next = ST_SLEEP;
                else
                    cnt_next = cnt_reg - 1'b1;
            end
            ST_LOCKOUT: begin
                if (!supply_low_i) begin
                    state_next = ST_WAKE;
                    cnt_next = cyc(WAKE_CYC) - 1'b1;
                end
            end
            default: state_next = ST_SLEEP;
        endcase
        // Undervoltage wins over every other mode
        if (supply_low_i) begin
            state_next = ST_LOCKOUT;
            testing_next = 1'b0;
        end
        // Power-up pulse of the flag
        if (pwr_first_reg)
            pup_next = cyc(PUP_CYC);
    end

    // ****************************************************************
    // Registers and outputs
    // ****************************************************************
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg <= ST_SLEEP;
            cnt_reg <= {CW{1'b0}};
            retry_reg <= {CW{1'b0}};
            pup_reg <= {CW{1'b0}};
            oc_reg <= 4'h0;
            old_reg <= 1'b0;
            hot_reg <= 1'b0;
            testing_reg <= 1'b0;
            pwr_first_reg <= 1'b1;
            fault_flag_n_out_o <= 1'b1;
            half_enable_o <= 4'h0;
            circuits_on_o <= 1'b0;
            ready_o <= 1'b0;
            output_one_sink_o <= 1'b0;
            output_one_source_o <= 1'b0;
            open_load_fault_o <= 1'b0;
            overcurrent_trip_o <= 1'b0;
            thermal_trip_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            retry_reg <= retry_next;
            pup_reg <= pup_next;
            oc_reg <= oc_next;
            old_reg <= old_next;
            hot_reg <= hot_next;
            testing_reg <= testing_next;
            pwr_first_reg <= 1'b0;
            // All faults and the power-up pulse pull the flag low
            fault_flag_n_out_o <= ~(supply_low_i | (|oc_next) | old_next |
                hot_next | (pup_next != {CW{1'b0}}));
            // Sleep and lockout shut circuits; others keep them on
            circuits_on_o <= ~state_next[0] & ~state_next[4];
            // Bridges only in run or during sleep entry delay
            if (state_next == ST_RUN || state_next == ST_SLEEPING)
                half_enable_o <= hot_next ? 4'h0 : ~oc_mask;
            else
                half_enable_o <= 4'h0;
            ready_o <= (state_next == ST_RUN);
            // Test current per load type; open load never stops bridges
            output_one_sink_o <= testing_next &
                (load_type_i == `BMFS_LOAD_TO_SUPPLY);
            output_one_source_o <= testing_next &
                (load_type_i != `BMFS_LOAD_TO_SUPPLY);
            open_load_fault_o <= old_next;
            overcurrent_trip_o <= |oc_next;
            thermal_trip_o <= hot_next;
        end
    end
endmodule

// file: tb/bmfs_chk_asserts.sv
// Assertion checker for the bridge mode and fault supervisor
`timescale 1ns/100ps
module bmfs_chk (
    input wire clk_i,
    input wire rstn_i,
    input wire sleep_bar_i,
    input wire supply_low_i,
    input wire fault_flag_n_out_o,
    input wire [3:0] half_enable_o,
    input wire circuits_on_o,
    input wire ready_o,
    input wire output_one_sink_o,
    input wire output_one_source_o,
    input wire open_load_fault_o,
    input wire overcurrent_trip_o,
    input wire thermal_trip_o
);
    // ****************************************
    // Mode and fault properties
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Pump comes up shortly after the pin is seen high
    sequence wake_s;
        ##[2:4] circuits_on_o;
    endsequence
    sleep_hiz_a: assert property
        (!circuits_on_o |-> half_enable_o == 4'h0)
        else $error("bridges enabled while circuits off");
    wake_auto_a: assert property
        ($rose(sleep_bar_i) && !supply_low_i |-> wake_s)
        else $error("no wake after sleep pin rise");
    sleep_hold_a: assert property
        ($fell(sleep_bar_i) && ready_o |-> circuits_on_o [*8])
        else $error("sleep entered too early");
    lockout_off_a: assert property
        (supply_low_i |-> ##[1:4] (!circuits_on_o &&
            half_enable_o == 4'h0 && !fault_flag_n_out_o))
        else $error("lockout did not shut down");
    fault_flag_a: assert property
        (open_load_fault_o || overcurrent_trip_o || thermal_trip_o |->
            ##[0:1] !fault_flag_n_out_o)
        else $error("fault without flag");
    retry_hold_a: assert property
        ($rose(overcurrent_trip_o) |-> overcurrent_trip_o [*8])
        else $error("overcurrent retry too early");
    ready_late_a: assert property
        ($rose(ready_o) |-> $past(circuits_on_o, 8) && !output_one_sink_o &&
            !output_one_source_o)
        else $error("ready before wake or test end");
    load_keep_a: assert property
        (open_load_fault_o && sleep_bar_i && $past(sleep_bar_i, 4) |=>
            open_load_fault_o)
        else $error("open load flag dropped while awake");
endmodule
bind bmfs_top bmfs_chk u_chk (.clk_i, .rstn_i, .sleep_bar_i, .supply_low_i,
    .fault_flag_n_out_o, .half_enable_o, .circuits_on_o, .ready_o,
    .output_one_sink_o, .output_one_source_o, .open_load_fault_o, .overcurrent_trip_o,
    .thermal_trip_o);

// file: tb/bmfs_host.sv
// Host model that drives the sleep pin
`timescale 1ns/100ps
module bmfs_host (
    input wire clk_i,
    input wire wake_req_i,
    output reg sleep_bar_o = 1'h0
);
    // Pin moves just after a falling edge; bench waits ready before use
    always @(negedge clk_i) begin
        sleep_bar_o <= wake_req_i;
    end
endmodule

// file: tb/tb_bmfs_top.sv
// Self-checking bench for the bridge mode and fault supervisor
`timescale 1ns/100ps
module tb_bmfs_top;
    localparam SL = 40;
    localparam RT = 50;
    reg clk_i = 1'h0;
    reg rstn_i = 1'h0;
    reg wake = 1'h0;
    reg [1:0] mode = 2'h0;
    reg [1:0] load = 2'h0;
    reg low = 1'h0, hot = 1'h0, cool = 1'h1, lo = 1'h0, hi = 1'h0;
    reg [3:0] oc = 4'h0, opn = 4'h0;
    wire sb, flag_n, circ, rdy, snk, src, olf, oct, tht;
    wire [3:0] hen;
    integer mismatches = 0, n_tests = 0, cyc = 0, i, k;
    // Row: mode, load, lo, hi, open, enables under overcurrent, open-load verdict
    reg [14:0] rows [0:5];
    bmfs_host u_host (.clk_i(clk_i), .wake_req_i(wake), .sleep_bar_o(sb));
    bmfs_top #(.WAKE_CYC(40), .SLEEP_CYC(SL), .RETRY_CYC(RT), .PUP_CYC(5),
        .OLD_CYC(10), .CW(17)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .sleep_bar_i(sb), .if_mode_i(mode), .load_type_i(load),
        .supply_low_i(low), .oc_half_i(oc), .thermal_hot_i(hot),
        .thermal_cool_i(cool), .output_one_low_side_sense_i(lo),
        .output_one_high_side_sense_i(hi), .old_bridge_open_i(opn),
        .fault_flag_n_out_o(flag_n), .half_enable_o(hen),
        .circuits_on_o(circ), .ready_o(rdy), .output_one_sink_o(snk),
        .output_one_source_o(src), .open_load_fault_o(olf),
        .overcurrent_trip_o(oct), .thermal_trip_o(tht));
    // Clock and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task cyc_n(input integer n);
        begin
            repeat (n) @(negedge clk_i);
        end
    endtask
    task wait_rdy;
        begin
            for (k = 0; k < 200 && rdy !== 1'h1; k = k + 1) begin
                @(negedge clk_i);
            end
            chk({7'h0, rdy}, 8'h01);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Main sequence: reset, table loop, then awkward cases
    initial begin
        rows[0] = {2'h0, 2'h1, 1'h1, 1'h0, 4'h0, 4'hC, 1'h0};
        rows[1] = {2'h1, 2'h1, 1'h0, 1'h1, 4'h0, 4'hC, 1'h1};
        rows[2] = {2'h2, 2'h2, 1'h0, 1'h1, 4'h0, 4'h0, 1'h0};
        rows[3] = {2'h3, 2'h2, 1'h1, 1'h0, 4'h0, 4'hE, 1'h1};
        rows[4] = {2'h2, 2'h0, 1'h0, 1'h0, 4'hF, 4'h0, 1'h1};
        rows[5] = {2'h3, 2'h0, 1'h1, 1'h1, 4'h0, 4'hE, 1'h0};
        cyc_n(10);
        chk({2'h0, flag_n, circ, hen}, 8'h20);
        rstn_i = 1'h1;
        cyc_n(2);
        chk({7'h0, flag_n}, 8'h00);
        cyc_n(10);
        chk({7'h0, flag_n}, 8'h01);
        for (i = 0; i < 6; i = i + 1) begin
            {mode, load, lo, hi, opn} = rows[i][14:5];
            wake = 1'h1;
            cyc_n(6);
            // Supply load is sunk; ground and bridge loads are sourced
            chk({5'h0, rdy, snk, src},
                (load == 2'h1) ? 8'h02 : 8'h01);
            wait_rdy;
            chk({2'h0, olf, flag_n, hen},
                {2'h0, rows[i][0], ~rows[i][0], 4'hF});
            oc = 4'h1;
            cyc_n(4);
            chk({3'h0, oct, hen}, {4'h1, rows[i][4:1]});
            chk({7'h0, flag_n}, 8'h00);
            oc = 4'h0;
            cyc_n(RT + 4);
            chk({3'h0, oct, hen}, 8'h0F);
            chk({7'h0, olf}, {7'h0, rows[i][0]});
            wake = 1'h0;
            cyc_n(SL + 6);
            chk({2'h0, circ, rdy, hen}, 8'h00);
        end
        wake = 1'h1;
        wait_rdy;
        wake = 1'h0;
        cyc_n(10);
        wake = 1'h1;
        cyc_n(6);
        chk({2'h0, circ, rdy, hen}, 8'h3F);
        hot = 1'h1;
        cool = 1'h0;
        cyc_n(4);
        chk({2'h0, tht, flag_n, hen}, 8'h20);
        hot = 1'h0;
        cool = 1'h1;
        cyc_n(4);
        chk({2'h0, tht, flag_n, hen}, 8'h1F);
        low = 1'h1;
        cyc_n(4);
        chk({2'h0, circ, flag_n, hen}, 8'h00);
        low = 1'h0;
        cyc_n(3);
        chk({7'h0, rdy}, 8'h00);
        wait_rdy;
        chk({3'h0, flag_n, hen}, 8'h1F);
        finish_test;
    end
endmodule
